// ===== core/ecpo_pkg.sv
// package: register map, field layout and shared types of the capture/pwm unit
package ecpo_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_DUTY_HIGH = 8'h04;
  localparam logic [7:0] ADDR_DEADBAND = 8'h08;
  localparam logic [7:0] ADDR_STEERING = 8'h0C;
  localparam logic [7:0] ADDR_COMPARE = 8'h10;
  localparam logic [7:0] ADDR_CAPTURE = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int ARR_LSB = 6;
  localparam int DUTY_LOW_LSB = 4;
  localparam int MODE_LSB = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DUTY_HIGH_RESET = 8'h00;
  localparam logic [6:0] DEADBAND_RESET = 7'h00;
  localparam logic [3:0] STEERING_RESET = 4'h1;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam int STATUS_FLAG_BIT = 0;
  localparam int STATUS_RUN_BIT = 1;

  // ----------------------------------------------------------------
  // timing: one instruction cycle is four oscillator periods
  // ----------------------------------------------------------------
  localparam int INSTR_CLOCKS = 4;

  // ----------------------------------------------------------------
  // mode and arrangement encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
  localparam logic [1:0] ARR_SINGLE = 2'h0;
  localparam logic [1:0] ARR_FWD = 2'h1;
  localparam logic [1:0] ARR_HALF = 2'h2;
  localparam logic [1:0] ARR_REV = 2'h3;

  // four bridge outputs travel together: a, b, c, d
  typedef struct packed {
    logic d;
    logic c;
    logic b;
    logic a;
  } ecpo_outs_t;

endpackage

// ===== core/ecpo_top.sv
// top: capture/compare/pwm unit with apb register slave
// ------------------------------------------------------------------
// ------------------------------------------------------------------
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps

module ecpo_top
#(
  parameter int TIMER_W = 16,
  parameter int DB_W = 7
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TIMER_W-1:0] cc_timer_count,
  input wire logic [7:0] pwm_timebase_count,
  input wire logic [1:0] pwm_timebase_fine,
  input wire logic pwm_period_match,
  input wire logic capture_in,
  output logic special_event_trigger,
  output logic unit_event_pulse,
  output ecpo_pkg::ecpo_outs_t pin_out,
  output ecpo_pkg::ecpo_outs_t pin_owned
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] duty_high;
    logic [DB_W-1:0] deadband_count;
    logic [3:0] steering;
    logic [TIMER_W-1:0] compare_value;
    logic [TIMER_W-1:0] capture_value;
    logic event_flag;
    logic cmp_pin;
    logic cap_prev;
    logic [3:0] cap_div;
    logic pwm_run;
    logic pwm_wave;
    logic [9:0] duty_latched;
    logic [DB_W+1:0] db_a;
    logic [DB_W+1:0] db_b;
    logic trig;
    logic evt;
    logic [31:0] rdata;
    ecpo_pkg::ecpo_outs_t outs;
  } ecpo_state_t;

  ecpo_state_t s;
  ecpo_state_t next_s;

  logic [3:0] mode;
  logic [1:0] arr;
  logic pwm_mode;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic cmp_match;
  logic cap_edge;
  logic [DB_W+1:0] db_limit;
  logic [9:0] phase;
  ecpo_pkg::ecpo_outs_t raw;
  ecpo_pkg::ecpo_outs_t pol;
  ecpo_pkg::ecpo_outs_t own;

  assign mode = s.control[ecpo_pkg::MODE_LSB +: 4];
  assign arr = s.control[ecpo_pkg::ARR_LSB +: 2];
  assign pwm_mode = mode[3] & mode[2];
  assign phase = {pwm_timebase_count, pwm_timebase_fine};
  assign db_limit = (DB_W + 2)'(s.deadband_count * ecpo_pkg::INSTR_CLOCKS);

  // ----------------------------------------------------------------
  // apb slave: zero wait states, unmapped address gives pslverr
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign prdata = s.rdata;

  always_comb
  begin
    case (paddr)
      ecpo_pkg::ADDR_CONTROL,
      ecpo_pkg::ADDR_DUTY_HIGH,
      ecpo_pkg::ADDR_DEADBAND,
      ecpo_pkg::ADDR_STEERING,
      ecpo_pkg::ADDR_COMPARE,
      ecpo_pkg::ADDR_CAPTURE,
      ecpo_pkg::ADDR_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~addr_ok;

  // ----------------------------------------------------------------
  // capture/compare event detection
  // ----------------------------------------------------------------
  assign cmp_match = (cc_timer_count == s.compare_value);

  always_comb
  begin
    case (mode)
      ecpo_pkg::MODE_CAP_FALL: cap_edge = s.cap_prev & ~capture_in;
      ecpo_pkg::MODE_CAP_RISE,
      ecpo_pkg::MODE_CAP_RISE4,
      ecpo_pkg::MODE_CAP_RISE16: cap_edge = ~s.cap_prev & capture_in;
      default: cap_edge = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] rd;
    logic cap_take;
    logic [9:0] duty_new;
    rd = 32'h0000_0000;
    cap_take = 1'b0;
    duty_new = {s.duty_high, s.control[ecpo_pkg::DUTY_LOW_LSB +: 2]};
    next_s = s;
    next_s.trig = 1'b0;
    next_s.evt = 1'b0;
    next_s.cap_prev = capture_in;

    // register writes
    if (wr_en)
    begin
      case (paddr)
        ecpo_pkg::ADDR_CONTROL: next_s.control = pwdata[7:0];
        ecpo_pkg::ADDR_DUTY_HIGH: next_s.duty_high = pwdata[7:0];
        ecpo_pkg::ADDR_DEADBAND: next_s.deadband_count = pwdata[DB_W-1:0];
        ecpo_pkg::ADDR_STEERING: next_s.steering = pwdata[3:0];
        ecpo_pkg::ADDR_COMPARE:
          next_s.compare_value = pwdata[TIMER_W-1:0];
        ecpo_pkg::ADDR_STATUS:
          if (pwdata[ecpo_pkg::STATUS_FLAG_BIT])
            next_s.event_flag = 1'b0;
        default: next_s.event_flag = next_s.event_flag;
      endcase
    end

    // register reads, latched in setup phase
    if (rd_en)
    begin
      case (paddr)
        ecpo_pkg::ADDR_CONTROL: rd[7:0] = s.control;
        ecpo_pkg::ADDR_DUTY_HIGH: rd[7:0] = s.duty_high;
        ecpo_pkg::ADDR_DEADBAND: rd[DB_W-1:0] = s.deadband_count;
        ecpo_pkg::ADDR_STEERING: rd[3:0] = s.steering;
        ecpo_pkg::ADDR_COMPARE: rd[TIMER_W-1:0] = s.compare_value;
        ecpo_pkg::ADDR_CAPTURE: rd[TIMER_W-1:0] = s.capture_value;
        ecpo_pkg::ADDR_STATUS:
        begin
          rd[ecpo_pkg::STATUS_FLAG_BIT] = s.event_flag;
          rd[ecpo_pkg::STATUS_RUN_BIT] = s.pwm_run;
        end
        default: rd = 32'h0000_0000;
      endcase
      next_s.rdata = rd;
    end

    // capture and compare behaviour
    case (mode)
      ecpo_pkg::MODE_OFF:
      begin
        // off clears internal state; registers stay as written
        next_s.cmp_pin = 1'b0;
        next_s.cap_div = 4'h0;
        next_s.pwm_run = 1'b0;
        next_s.pwm_wave = 1'b0;
      end
      ecpo_pkg::MODE_TOGGLE:
        if (cmp_match)
          next_s.cmp_pin = ~s.cmp_pin;
      ecpo_pkg::MODE_CAP_FALL,
      ecpo_pkg::MODE_CAP_RISE:
        cap_take = cap_edge;
      ecpo_pkg::MODE_CAP_RISE4:
        if (cap_edge)
        begin
          next_s.cap_div = s.cap_div + 4'h1;
          cap_take = (s.cap_div[1:0] == 2'h3);
        end
      ecpo_pkg::MODE_CAP_RISE16:
        if (cap_edge)
        begin
          next_s.cap_div = s.cap_div + 4'h1;
          cap_take = (s.cap_div == 4'hF);
        end
      ecpo_pkg::MODE_CMP_SET:
        if (cmp_match)
        begin
          next_s.cmp_pin = 1'b1;
          next_s.evt = 1'b1;
        end
      ecpo_pkg::MODE_CMP_CLR:
        if (cmp_match)
        begin
          next_s.cmp_pin = 1'b0;
          next_s.evt = 1'b1;
        end
      ecpo_pkg::MODE_CMP_SOFT:
        if (cmp_match)
          next_s.evt = 1'b1;
      ecpo_pkg::MODE_CMP_TRIG:
        if (cmp_match)
        begin
          next_s.trig = 1'b1;
          next_s.evt = 1'b1;
        end
      default: next_s.cap_div = s.cap_div; // reserved and pwm codes: no capture/compare function
    endcase

    // compare pin start level when a compare mode is written
    if (wr_en && paddr == ecpo_pkg::ADDR_CONTROL)
    begin
      if (pwdata[3:0] == ecpo_pkg::MODE_CMP_SET)
        next_s.cmp_pin = 1'b0;
      else if (pwdata[3:0] == ecpo_pkg::MODE_CMP_CLR)
        next_s.cmp_pin = 1'b1;
      next_s.cap_div = 4'h0;
    end

    if (cap_take)
    begin
      next_s.capture_value = cc_timer_count;
      next_s.evt = 1'b1;
    end
    // set wins over a clear in the same cycle
    if (next_s.evt)
      next_s.event_flag = 1'b1;

    // pwm timebase: waveform restarts at each period boundary
    if (!pwm_mode)
    begin
      next_s.pwm_run = 1'b0;
      next_s.pwm_wave = 1'b0;
      next_s.db_a = '0;
      next_s.db_b = '0;
    end
    else if (pwm_period_match)
    begin
      next_s.pwm_run = 1'b1;
      next_s.duty_latched = duty_new;
      next_s.pwm_wave = (duty_new != 10'h000);
      next_s.db_a = '0;
      next_s.db_b = '0;
    end
    else if (s.pwm_run)
    begin
      if (phase >= s.duty_latched)
        next_s.pwm_wave = 1'b0;
      // dead-band counters: time spent with each side asked active
      if (s.pwm_wave)
        next_s.db_a = (s.db_a == db_limit) ? s.db_a : s.db_a + 1'b1;
      else
        next_s.db_a = '0;
      if (!s.pwm_wave)
        next_s.db_b = (s.db_b == db_limit) ? s.db_b : s.db_b + 1'b1;
      else
        next_s.db_b = '0;
    end

    // output arrangement before polarity
    raw = '0;
    if (!pwm_mode)
      raw.a = s.cmp_pin;
    else if (s.pwm_run)
    begin
      case (arr)
        ecpo_pkg::ARR_SINGLE:
          raw = s.pwm_wave ? ecpo_pkg::ecpo_outs_t'(s.steering) : '0;
        ecpo_pkg::ARR_FWD:
        begin
          raw.a = 1'b1;
          raw.d = s.pwm_wave;
        end
        ecpo_pkg::ARR_HALF:
        begin
          // active only after the dead-band has elapsed; a band longer
          // than the active time never completes, so the side stays off
          raw.a = s.pwm_wave & (s.db_a >= db_limit);
          raw.b = ~s.pwm_wave & (s.db_b >= db_limit);
        end
        ecpo_pkg::ARR_REV:
        begin
          raw.c = 1'b1;
          raw.b = s.pwm_wave;
        end
        default: raw = '0;
      endcase
    end

    // polarity per pair
    pol.a = raw.a ^ (pwm_mode & mode[1]);
    pol.c = raw.c ^ (pwm_mode & mode[1]);
    pol.b = raw.b ^ (pwm_mode & mode[0]);
    pol.d = raw.d ^ (pwm_mode & mode[0]);
    next_s.outs = pol;
  end

  // ----------------------------------------------------------------
  // pin ownership
  // ----------------------------------------------------------------
  always_comb
  begin
    own = '0;
    case (mode)
      ecpo_pkg::MODE_TOGGLE,
      ecpo_pkg::MODE_CMP_SET,
      ecpo_pkg::MODE_CMP_CLR,
      ecpo_pkg::MODE_CMP_TRIG: own.a = 1'b1;
      ecpo_pkg::MODE_CAP_FALL,
      ecpo_pkg::MODE_CAP_RISE,
      ecpo_pkg::MODE_CAP_RISE4,
      ecpo_pkg::MODE_CAP_RISE16: own = '0; // a is an input in capture
      ecpo_pkg::MODE_OFF,
      ecpo_pkg::MODE_CMP_SOFT: own = '0;
      default:
        if (pwm_mode)
        begin
          case (arr)
            ecpo_pkg::ARR_SINGLE:
              own = ecpo_pkg::ecpo_outs_t'(s.steering);
            ecpo_pkg::ARR_HALF:
            begin
              own.a = 1'b1;
              own.b = 1'b1;
            end
            default: own = 4'hF;
          endcase
        end
    endcase
  end

  assign pin_owned = own;
  assign pin_out = s.outs;
  assign special_event_trigger = s.trig;
  assign unit_event_pulse = s.evt;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.control <= ecpo_pkg::CONTROL_RESET;
      s.duty_high <= ecpo_pkg::DUTY_HIGH_RESET;
      s.deadband_count <= ecpo_pkg::DEADBAND_RESET;
      s.steering <= ecpo_pkg::STEERING_RESET;
      s.compare_value <= ecpo_pkg::COMPARE_RESET;
    end
    else
      s <= next_s;
  end

endmodule // ecpo_top

// ===== sim/ecpo_timebase_model.sv
// partner model: free-running pwm timebase with period-match pulse
`timescale 1ns/1ps
// ------------------------------------------------------------------
// timebase
// ------------------------------------------------------------------
module ecpo_timebase_model
#(
  parameter logic [7:0] PERIOD = 8'h03
)
(
  input wire logic sys_clk,
  input wire logic rst,
  output logic [7:0] count,
  output logic [1:0] fine,
  output logic match
);
  logic last;
  assign last = {count, fine} == {PERIOD, 2'h3};
  // wraps to zero and pulses once when the count meets the period
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      {count, fine, match} <= 11'h000;
    else
      {count, fine, match} <= last ? 11'h001 : {count, fine, 1'b0} + 11'h002;
endmodule // ecpo_timebase_model

// ===== sim/ecpo_top_asserts.sv
// checker: port-level properties of the capture/pwm unit
`timescale 1ns/1ps
// ------------------------------------------------------------------
// checker
// ------------------------------------------------------------------
module ecpo_top_chk
#(
  parameter int TIMER_W = 16
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [TIMER_W-1:0] cc_timer_count,
  input wire logic pwm_period_match,
  input wire logic special_event_trigger,
  input wire logic unit_event_pulse,
  input wire ecpo_pkg::ecpo_outs_t pin_out,
  input wire ecpo_pkg::ecpo_outs_t pin_owned
);
  logic [7:0] ctl;
  logic [TIMER_W-1:0] cmp;
  logic [1:0] age;
  logic run;
  logic wc;
  logic pwm;
  logic hit;
  logic [3:0] idle;
  assign wc = psel & penable & pwrite & pready & paddr == 8'h00;
  assign pwm = ctl[3:2] == 2'b11;
  assign idle = {ctl[0], ctl[1], ctl[0], ctl[1]};
  // shadow copies; age saturates so a settling window needs no wide count
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      {ctl, cmp, age, run} <= '0;
    else
    begin
      ctl <= wc ? pwdata[7:0] : ctl;
      age <= wc ? 2'h0 : age + {1'b0, age != 2'h3};
      if (psel & penable & pwrite & pready & paddr == 8'h10)
        cmp <= pwdata[TIMER_W-1:0];
      // running starts at the first period boundary seen in pwm mode
      run <= pwm & (run | pwm_period_match);
    end
  always_ff @(posedge sys_clk)
    hit <= cc_timer_count == cmp;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_rel;
    !pwm |-> pin_owned[3:1] == 3'h0;
  endproperty
  a_rel: assert property (p_rel) else $error("b c d held");
  property p_free;
    ctl[3:0] inside {4'h0, 4'h1, 4'h3, 4'hA} |-> pin_owned == 4'h0;
  endproperty
  a_free: assert property (p_free) else $error("pin held");
  property p_half;
    pwm && ctl[7:6] == 2'b10 |-> pin_owned == 4'h3;
  endproperty
  a_half: assert property (p_half) else $error("half pins");
  property p_gap;
    pwm && ctl[7:6] == 2'b10 && age == 2'h3 |->
      !((pin_out.a ^ ctl[1]) && (pin_out.b ^ ctl[0]));
  endproperty
  a_gap: assert property (p_gap) else $error("a b overlap");
  property p_wait;
    pwm && !run && age != 2'h0 |-> ((pin_out ^ idle) & pin_owned) == 4'h0;
  endproperty
  a_wait: assert property (p_wait) else $error("early wave");
  property p_lvl;
    ctl[3:1] == 3'b100 && unit_event_pulse && age == 2'h3 |=>
      pin_out.a == !$past(ctl[0]);
  endproperty
  a_lvl: assert property (p_lvl) else $error("match level");
  property p_trig;
    special_event_trigger |-> unit_event_pulse && ctl[3:0] == 4'hB && hit;
  endproperty
  a_trig: assert property (p_trig) else $error("bad trigger");
  property p_tog;
    ctl[3:0] == 4'h2 && age == 2'h3 && $changed(pin_out.a) |-> $past(hit);
  endproperty
  a_tog: assert property (p_tog) else $error("bad toggle");
  c_trig: cover property (special_event_trigger);
  c_half: cover property (pwm && run && ctl[7:6] == 2'b10);
  c_lvl: cover property (unit_event_pulse && ctl[3:1] == 3'b100);
  c_wait: cover property (pwm && !run && age != 2'h0);
endmodule // ecpo_top_chk

bind ecpo_top ecpo_top_chk #(.TIMER_W(TIMER_W)) u_chk (.sys_clk, .rst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .cc_timer_count,
  .pwm_period_match, .special_event_trigger, .unit_event_pulse, .pin_out,
  .pin_owned);

// ===== sim/ecpo_top_tb.sv
// testbench: registers, compare, capture and pwm of the capture/pwm unit
`timescale 1ns/1ps
// ------------------------------------------------------------------
// bench
// ------------------------------------------------------------------
module ecpo_top_tb;
  localparam logic [7:0] A_CTL = ecpo_pkg::ADDR_CONTROL;
  localparam logic [7:0] A_CAP = ecpo_pkg::ADDR_CAPTURE;
  localparam logic [7:0] A_STA = ecpo_pkg::ADDR_STATUS;
  localparam logic [15:0] CMPV = 16'h1234;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] cnt = 16'h0000;
  logic [7:0] t_cnt;
  logic [1:0] t_fine;
  logic t_match;
  logic cap = 1'b0;
  logic trg;
  logic ev;
  ecpo_pkg::ecpo_outs_t pin_out;
  ecpo_pkg::ecpo_outs_t pin_owned;
  int n_fail = 0;
  int compares = 0;
  logic [31:0] rd;
  logic err;
  logic e1;
  logic t1;
  int ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C};
  int cm[6] = '{4'h5, 4'h6, 4'h6, 4'h7, 4'h7, 4'h4};
  int cn[6] = '{8'h01, 8'h03, 8'h01, 8'h0F, 8'h01, 8'h01};
  int cr[6] = '{16'h0111, 16'h0222, 16'h0222, 16'h0333, 16'h0333, 16'h0555};
  int cf[6] = '{16'h0999, 16'h0222, 16'h0222, 16'h0333, 16'h0333, 16'h0444};
  int ce[6] = '{16'h0111, 16'h0111, 16'h0222, 16'h0222, 16'h0333, 16'h0444};
  initial forever #5 sys_clk = ~sys_clk;
  ecpo_timebase_model tmr (.sys_clk(sys_clk), .rst(rst), .count(t_cnt),
    .fine(t_fine), .match(t_match));
  ecpo_top dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cc_timer_count(cnt), .pwm_timebase_count(t_cnt),
    .pwm_timebase_fine(t_fine), .pwm_period_match(t_match),
    .capture_in(cap), .special_event_trigger(trg), .unit_event_pulse(ev),
    .pin_out(pin_out), .pin_owned(pin_owned));
  task summarize;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task fail_out;
    n_fail++;
    summarize;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1)
      fail_out;
  endtask
  // timer meets the compare value for exactly one cycle
  task hit;
    {e1, t1} = 2'b00;
    @(posedge sys_clk);
    cnt <= CMPV;
    @(posedge sys_clk);
    cnt <= CMPV + 16'h0100;
    repeat (4)
    begin
      @(posedge sys_clk);
      {e1, t1} = {e1 | ev, t1 | trg};
    end
  endtask
  task pulse(input int n, input logic [15:0] rv, input logic [15:0] fv);
    repeat (n)
    begin
      @(posedge sys_clk);
      cnt <= rv;
      @(posedge sys_clk);
      cap <= 1'b1;
      repeat (3) @(posedge sys_clk);
      cnt <= fv;
      @(posedge sys_clk);
      cap <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask
  task sync;
    int n;
    n = 0;
    do
      @(posedge sys_clk);
    while (t_match !== 1'b1 && ++n < 40);
    if (t_match !== 1'b1)
      fail_out;
  endtask
  // counts high cycles of each pin over one 16-cycle period; 1F skips
  task pwm_case(input logic [7:0] c, input logic [6:0] db,
                input logic [19:0] e);
    logic [4:0] n [4];
    apb(1'b1, ecpo_pkg::ADDR_DEADBAND, {25'h0, db});
    apb(1'b1, A_CTL, {24'h0, c});
    sync;
    sync;
    n = '{default: 5'h00};
    repeat (16)
    begin
      @(posedge sys_clk);
      for (int k = 0; k < 4; k++)
        n[k] += {4'h0, pin_out[k]};
    end
    for (int k = 0; k < 4; k++)
      if (e[5*k +: 5] != 5'h1F)
        chk({27'h0, n[k]}, {27'h0, e[5*k +: 5]});
  endtask
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, ra[i][7:0], 32'h0);
      chk(rd, {31'h0, i == 3});
      chk(err, i == 6);
    end
    $display("test registers done");
    apb(1'b1, ecpo_pkg::ADDR_COMPARE, {16'h0, CMPV});
    for (int i = 8; i < 12; i++)
    begin
      apb(1'b1, A_CTL, i);
      repeat (2) @(posedge sys_clk);
      if (i < 10) chk(pin_out.a, i - 8);
      hit;
      chk(e1, 1'b1);
      chk(t1, i == 11);
      if (i < 10) chk(pin_out.a, 9 - i);
      if (i == 10) chk(pin_owned.a, 1'b0);
    end
    apb(1'b0, A_STA, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, A_STA, 32'h1);
    apb(1'b0, A_STA, 32'h0);
    chk(rd[0], 1'b0);
    apb(1'b1, A_CTL, 32'h0);
    apb(1'b1, A_CTL, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk(pin_out.a, 1'b0);
    for (int k = 1; k < 3; k++)
    begin
      hit;
      chk(pin_out.a, k % 2);
    end
    $display("test compare done");
    for (int i = 0; i < 6; i++)
    begin
      // rewriting the mode would restart the edge divider
      if (i == 0 || cm[i] != cm[i-1]) apb(1'b1, A_CTL, cm[i]);
      pulse(cn[i], cr[i][15:0], cf[i][15:0]);
      apb(1'b0, A_CAP, 32'h0);
      chk(rd, ce[i]);
    end
    $display("test capture done");
    apb(1'b1, A_CTL, 32'h0);
    apb(1'b1, ecpo_pkg::ADDR_DUTY_HIGH, 32'h2);
    apb(1'b1, ecpo_pkg::ADDR_STEERING, 32'hF);
    // enable just after a boundary: idle until the next one
    sync;
    apb(1'b1, A_CTL, 32'h1C);
    apb(1'b0, A_STA, 32'h0);
    chk(rd[1], 1'b0);
    chk(pin_out, 4'h0);
    sync;
    apb(1'b0, A_STA, 32'h0);
    chk(rd[1], 1'b1);
    pwm_case(8'h1C, 7'h00, {5'h09, 5'h09, 5'h09, 5'h09});
    pwm_case(8'h1D, 7'h00, {5'h07, 5'h09, 5'h07, 5'h09});
    pwm_case(8'h1E, 7'h00, {5'h09, 5'h07, 5'h09, 5'h07});
    pwm_case(8'h1F, 7'h00, {5'h07, 5'h07, 5'h07, 5'h07});
    pwm_case(8'h5C, 7'h00, {5'h09, 5'h00, 5'h00, 5'h10});
    pwm_case(8'hDC, 7'h00, {5'h00, 5'h10, 5'h09, 5'h00});
    pwm_case(8'h9C, 7'h00, {5'h1F, 5'h1F, 5'h07, 5'h09});
    pwm_case(8'h9C, 7'h01, {5'h1F, 5'h1F, 5'h03, 5'h05});
    pwm_case(8'h9C, 7'h03, {5'h1F, 5'h1F, 5'h00, 5'h00});
    $display("test pwm done");
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, A_CTL, i == 2 ? 32'hC0 : 32'h1 + 2 * i);
      @(posedge sys_clk);
      chk(pin_owned, 4'h0);
      apb(1'b0, A_CTL, 32'h0);
      chk(rd, i == 2 ? 32'hC0 : 32'h1 + 2 * i);
    end
    $display("test release done");
    summarize;
  end
endmodule // ecpo_top_tb
